// ---- lpfsc_ana_model.sv ----
`default_nettype none
module lpfsc_ana_model import lpfsc_pkg::*; (
	input wire logic ref_clk_in,
	input wire logic [NUM_OUT-1:0] en_in,
	input wire logic slow_in,
	input wire logic uvlo_in,
	input wire logic therm_in,
	input wire logic ov_in,
	input wire logic uv_in
	,
	output lpfsc_ana_s ana_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************
	// regulator ramp
	// ****************
	logic [NUM_OUT-1:0] pg_r [0:5];
	logic [NUM_OUT-1:0] pg;
	always_ff @(posedge ref_clk_in) begin
		pg_r[0] <= en_in;
		for (int i = 1; i < 6; i++) begin
			pg_r[i] <= pg_r[i-1];
		end
	end
	// good drops at once on disable, so a stale good never masks a fault
	assign pg = (slow_in ? pg_r[5] : pg_r[1]) & en_in;
	always_comb begin
		ana_out = '0;
		ana_out.uvlo = uvlo_in;
		ana_out.vin_ok = !uvlo_in;
		ana_out.therm = therm_in;
		ana_out.pgood = pg;
		ana_out.ss_done = pg;
		ana_out.ov[0] = ov_in & pg[0];
		ana_out.uv[0] = uv_in & pg[0];
	end
endmodule // lpfsc_ana_model
`default_nettype wire

// ---- lpfsc_bench.sv ----
`default_nettype none
module lpfsc_bench import lpfsc_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	// short tick keeps the fault hold near 800 cycles
	localparam int TK = 4;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	lpfsc_ana_s ana;
	lpfsc_out_cfg_s [NUM_OUT-1:0] cfg;
	logic [NUM_PIN-1:0] gpio, pol, slp_sel, pe_sel;
	logic [NUM_PIN-1:0] dp_sel = 7'h02;
	logic [1:0] dg, b2s, b2d, rdly, fdly;
	logic slp = 1'b0, slp_c = 1'b0, dp = 1'b0, dp_c = 1'b0, pe_edge = 1'b1;
	logic tmask = 1'b0, vdis = 1'b0, mwr = 1'b0, slow, uvlo = 1'b0;
	logic therm = 1'b0, ov = 1'b0, uv = 1'b0;
	logic [NUM_OUT-1:0] mwd = 5'h00;
	logic [NUM_OUT-1:0] en, ovm, uvm;
	logic b2sec, rst_n, thermal_warning_status, sbr;
	lpfsc_state_e st;
	lpfsc_state_e prev = ST_RESET;
	lpfsc_state_e exp_q[$];
	integer seed = 32'hDBB3;
	int n_mismatch = 0;
	int check_count = 0;
	int cnt;
	bit mon = 1'b0;
	always #25 ref_clk = ~ref_clk;
	lpfsc_top #(.TICK_CYCLES(TK)) u_dut (
		.ref_clk_in(ref_clk),
		.rst_in(rst),
		.ana_in(ana),
		.gpio_in(gpio),
		.gpio_polarity_in(pol),
		.deglitch_sel_in(dg),
		.sleep_request_bit_in(slp),
		.sleep_combine_sel_in(slp_c),
		.deep_sleep_request_bit_in(dp),
		.deep_sleep_combine_sel_in(dp_c),
		.sleep_pin_sel_in(slp_sel),
		.deep_sleep_pin_sel_in(dp_sel),
		.power_enable_pin_sel_in(pe_sel),
		.power_enable_edge_mode_in(pe_edge),
		.out_cfg_in(cfg),
		.buck2_sleep_mode_in(b2s),
		.buck2_deep_mode_in(b2d),
		.pin_rise_dly_sel_in(rdly),
		.pin_fall_dly_sel_in(fdly),
		.thermal_state_mask_in(tmask),
		.voltage_fault_shutdown_disable_in(vdis),
		.mask_wr_in(mwr),
		.overvoltage_mask_wdata_in(mwd),
		.undervoltage_mask_wdata_in(mwd),
		.state_out(st),
		.out_en_out(en),
		.buck2_secondary_out(b2sec),
		.reset_n_out(rst_n),
		.thermal_warning_status_out(thermal_warning_status),
		.overvoltage_mask_out(ovm),
		.undervoltage_mask_out(uvm),
		.serial_bus_reset_out(sbr)
	);
	lpfsc_ana_model u_ana (
		.ref_clk_in(ref_clk),
		.en_in(en),
		.slow_in(slow),
		.uvlo_in(uvlo),
		.therm_in(therm),
		.ov_in(ov),
		.uv_in(uv),
		.ana_out(ana)
	);
	// ****************
	// helpers
	// ****************
	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] ex);
		check_count++;
		if (seen !== ex) begin
			n_mismatch++;
			$display("ERROR %s expected %0h seen %0h", nm, ex, seen);
		end
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic wst(input lpfsc_state_e s);
		cnt = 0;
		while (st !== s && cnt < 3000) begin
			@(negedge ref_clk);
			cnt++;
		end
		if (st !== s)
			n_mismatch++;
	endtask
	task automatic req(input bit d, input bit b, input bit p);
		@(posedge ref_clk);
		if (d) begin
			dp <= b;
			gpio[1] <= p ^ pol[1];
		end else begin
			slp <= b;
			gpio[0] <= p ^ pol[0];
		end
	endtask
	function automatic logic [NUM_OUT-1:0] pat(input bit d);
		for (int i = 0; i < NUM_OUT; i++) begin
			pat[i] = (i == BUCK2_IDX) ? ((d ? b2d : b2s) != B2_OFF) :
				(d ? cfg[i].deep_sleep_request_bit_on : cfg[i].sleep_on);
		end
	endfunction
	task automatic lp(input bit d, input bit c);
		lpfsc_state_e s;
		s = d ? ST_DEEP_SLEEP_REQUEST_BIT : ST_SLEEP;
		@(posedge ref_clk);
		slp_c <= c;
		dp_c <= c;
		if (!c) begin
			req(d, 1'b1, 1'b0);
			cyc(150);
		end
		exp_q.push_back(s);
		req(d, !c, 1'b1);
		wst(s);
		for (int i = 0; i < NUM_OUT; i++) begin
			if (cfg[i].off_dly_sel != 2'h0)
				chk("off_hold", en[i], 1'b1);
		end
		cyc(120);
		@(negedge ref_clk);
		chk("pattern", en, pat(d));
		chk("b2_sec", b2sec, (d ? b2d : b2s) == B2_SECONDARY);
		cyc(1);
		if (c) begin
			req(d, 1'b1, 1'b1);
			req(d, 1'b1, 1'b0);
			cyc(150);
		end
		exp_q.push_back(ST_ACTIVE);
		req(d, !c, 1'b0);
		cyc(150);
		req(d, 1'b0, 1'b0);
		cyc(150);
	endtask
	// ****************
	// state watcher
	// ****************
	always @(negedge ref_clk) begin
		if (mon && st !== prev) begin
			prev = st;
			if (exp_q.size() == 0)
				chk("state_extra", st, 32'hFF);
			else
				chk("state", st, exp_q.pop_front());
			chk("reset_n", rst_n,
				!(st inside {ST_RESET, ST_THERMAL, ST_VFAULT}));
			chk("bus_rst", sbr,
				st inside {ST_RESET, ST_THERMAL, ST_VFAULT});
		end
	end
	initial begin
		repeat (20000) @(posedge ref_clk);
		n_mismatch++;
		close_out;
	end
	// ****************
	// scenarios
	// ****************
	initial begin
		for (int i = 0; i < NUM_OUT; i++) begin
			cfg[i] = lpfsc_out_cfg_s'($random(seed));
			cfg[i].pin_ctl_en = 1'b0;
		end
		b2s = 2'($unsigned($random(seed)) % 3);
		b2d = 2'($unsigned($random(seed)) % 3);
		{dg, rdly, fdly} = 6'($random(seed));
		pol = 7'($random(seed)) & 7'h03;
		slow = 1'($random(seed));
		gpio = pol | 7'h04;
		slp_sel = 7'h00;
		// enable pin off until lockout: a high pin blocks and-mode deep-sleep
		pe_sel = 7'h00;
		exp_q.push_back(ST_START);
		exp_q.push_back(ST_ACTIVE);
		cyc(4);
		rst <= 1'b0;
		mon <= 1'b1;
		cyc(200);
		@(negedge ref_clk);
		chk("mask_up", {ovm, uvm}, 10'h000);
		cyc(1);
		exp_q.push_back(ST_SLEEP);
		slp <= 1'b1;
		cyc(100);
		exp_q.push_back(ST_ACTIVE);
		slp <= 1'b0;
		slp_sel <= 7'h01;
		cyc(100);
		for (int d = 0; d < 2; d++) begin
			for (int c = 0; c < 2; c++)
				lp(d[0], c[0]);
		end
		exp_q.push_back(ST_THERMAL);
		therm <= 1'b1;
		cyc(20);
		@(negedge ref_clk);
		chk("therm_off", en, 5'h00);
		cyc(1);
		exp_q.push_back(ST_START);
		exp_q.push_back(ST_ACTIVE);
		therm <= 1'b0;
		cyc(200);
		tmask <= 1'b1;
		therm <= 1'b1;
		cyc(20);
		@(negedge ref_clk);
		chk("thermal_warning_status", thermal_warning_status, 1'b1);
		cyc(1);
		therm <= 1'b0;
		// gate held until the synchronised flag has drained
		cyc(5);
		tmask <= 1'b0;
		vdis <= 1'b1;
		uv <= 1'b1;
		cyc(100);
		uv <= 1'b0;
		cyc(5);
		vdis <= 1'b0;
		mwd <= 5'h1F;
		mwr <= 1'b1;
		cyc(1);
		mwr <= 1'b0;
		cyc(2);
		@(negedge ref_clk);
		chk("mask_wr", ovm, 5'h1F);
		cyc(1);
		ov <= 1'b1;
		cyc(100);
		ov <= 1'b0;
		cyc(5);
		mwd <= 5'h00;
		mwr <= 1'b1;
		cyc(1);
		mwr <= 1'b0;
		cyc(20);
		repeat (2) exp_q.push_back(ST_VFAULT);
		exp_q.insert(1, ST_ACTIVE);
		exp_q.push_back(ST_ACTIVE);
		ov <= 1'b1;
		wst(ST_VFAULT);
		cnt = 0;
		while (st === ST_VFAULT && cnt < 2000) begin
			@(negedge ref_clk);
			cnt++;
		end
		chk("hold", cnt >= (int'(FAULT_TK) - 1) * TK &&
			cnt <= (int'(FAULT_TK) + 1) * TK, 1'b1);
		wst(ST_VFAULT);
		repeat (3) @(negedge ref_clk);
		chk("vf_off", en, 5'h00);
		cyc(1);
		ov <= 1'b0;
		cyc(1000);
		exp_q.push_back(ST_RESET);
		uvlo <= 1'b1;
		cyc(20);
		@(negedge ref_clk);
		chk("mask_def", {ovm, uvm}, 10'h3FF);
		cyc(1);
		pe_edge <= 1'b0;
		pe_sel <= 7'h04;
		gpio[2] <= 1'b0;
		cyc(150);
		exp_q.push_back(ST_DEEP_SLEEP_REQUEST_BIT);
		uvlo <= 1'b0;
		cyc(200);
		exp_q.push_back(ST_ACTIVE);
		pe_edge <= 1'b1;
		gpio[2] <= 1'b1;
		cyc(200);
		exp_q.push_back(ST_DEEP_SLEEP_REQUEST_BIT);
		gpio[2] <= 1'b0;
		cyc(200);
		chk("queue_left", exp_q.size(), 32'h0);
		close_out;
	end
endmodule // lpfsc_bench
`default_nettype wire

// ---- lpfsc_out_seq.sv ----
`default_nettype none
module lpfsc_out_seq import lpfsc_pkg::*; (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic tick_in,
	input wire logic force_off_in,
	input wire logic [NUM_OUT-1:0] target_in,
	input wire logic [NUM_OUT-1:0][1:0] on_sel_in,
	input wire logic [NUM_OUT-1:0][1:0] off_sel_in,
	output logic [NUM_OUT-1:0] en_out
);
	typedef struct packed {
		logic [NUM_OUT-1:0] on;
		logic [NUM_OUT-1:0][CNT_W-1:0] cnt;
	} lpfsc_seq_s;
	lpfsc_seq_s q, d;
	logic [NUM_OUT-1:0] on_n;
	logic [NUM_OUT-1:0][CNT_W-1:0] cnt_n;
	genvar g;
	for (g = 0; g < NUM_OUT; g++) begin : g_out
		logic [CNT_W-1:0] lim;
		logic go, diff;
		assign lim = target_in[g] ? lpfsc_dly_ticks(on_sel_in[g]) :
			lpfsc_dly_ticks(off_sel_in[g]);
		assign diff = target_in[g] != q.on[g];
		assign go = q.cnt[g] >= lim;
		// R3: switch once delay spent
		assign on_n[g] = force_off_in ? 1'b0 :
			((diff && go) ? target_in[g] : q.on[g]);
		assign cnt_n[g] = (force_off_in || !diff || go) ? '0 :
			(tick_in ? q.cnt[g] + CNT_ONE : q.cnt[g]);
	end
	always_comb begin
		d = q;
		d.on = on_n;
		d.cnt = cnt_n;
	end
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
	assign en_out = q.on;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);
	AST_FORCE_OFF: assert property ( // R19
		force_off_in |=> en_out == '0)
		else $error("outputs stayed on under forced shutdown");
endmodule // lpfsc_out_seq
`default_nettype wire

// ---- lpfsc_pin_cond.sv ----
`default_nettype none
module lpfsc_pin_cond import lpfsc_pkg::*; (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic tick_in,
	input wire logic [NUM_PIN-1:0] pin_in,
	input wire logic [NUM_PIN-1:0] polarity_in,
	input wire logic [1:0] deglitch_sel_in,
	output logic [NUM_PIN-1:0] level_out,
	output logic ready_out
);
	typedef struct packed {
		logic [NUM_PIN-1:0] s1;
		logic [NUM_PIN-1:0] s2;
		logic [NUM_PIN-1:0] filt;
		logic [NUM_PIN-1:0][CNT_W-1:0] cnt;
		logic [1:0] prime;
	} lpfsc_pc_s;
	lpfsc_pc_s q, d;
	logic [NUM_PIN-1:0] lvl, filt_n;
	logic [NUM_PIN-1:0][CNT_W-1:0] cnt_n;
	logic [CNT_W-1:0] dg_tk;
	assign dg_tk = lpfsc_dg_ticks(deglitch_sel_in);
	// ************************************************
	// per pin polarity and deglitch
	// ************************************************
	genvar g;
	for (g = 0; g < NUM_PIN; g++) begin : g_pin
		logic same, hit;
		// R16: polarity then filter
		assign lvl[g] = q.s2[g] ^ polarity_in[g];
		assign same = lvl[g] == q.filt[g];
		assign hit = tick_in && ((q.cnt[g] + CNT_ONE) >= dg_tk);
		assign filt_n[g] = (!same && hit) ? lvl[g] : q.filt[g];
		assign cnt_n[g] = (same || hit) ? '0 :
			(tick_in ? q.cnt[g] + CNT_ONE : q.cnt[g]);
	end
	always_comb begin
		d = q;
		// R25: two flops first
		d.s1 = pin_in;
		d.s2 = q.s1;
		d.filt = filt_n;
		d.cnt = cnt_n;
		// preload so a held pin is seen at start-up without a glitch wait
		if (q.prime != PRIME_DONE) begin
			d.filt = lvl;
			d.cnt = '0;
			d.prime = q.prime + 2'h1;
		end
	end
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
	assign level_out = q.filt;
	assign ready_out = q.prime == PRIME_DONE;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);
	AST_DEGLITCH_TICK: assert property ( // R16
		($past(ready_out) && $changed(q.filt)) |-> $past(tick_in))
		else $error("filtered pin moved without a tick");
endmodule // lpfsc_pin_cond
`default_nettype wire

// ---- lpfsc_pkg.sv ----
`default_nettype none
package lpfsc_pkg;
	localparam int NUM_OUT = 5;
	localparam int NUM_PIN = 7;
	localparam int PIN_W = 3;
	localparam int CNT_W = 8;
	localparam int BUCK2_IDX = 1;
	localparam int CLK_PERIOD_NS = 50;
	localparam int NS_PER_US = 1000;
	localparam int US_PER_MS = 1000;
	// ************************************************
	// time base: one enable pulse every half millisecond
	// ************************************************
	localparam int TICK_US = 500;
	localparam int TICK_CYCLES_DEF = TICK_US * NS_PER_US / CLK_PERIOD_NS;
	localparam int DLY_0_US = 0;
	localparam int DLY_1_US = 1000;
	localparam int DLY_2P5_US = 2500;
	localparam int DLY_5_US = 5000;
	localparam int DG_1_US = 1000;
	localparam int DG_5_US = 5000;
	localparam int DG_10_US = 10000;
	localparam int FAULT_MS = 100;
	localparam logic [CNT_W-1:0] DLY0_TK = CNT_W'(DLY_0_US / TICK_US);
	localparam logic [CNT_W-1:0] DLY1_TK = CNT_W'(DLY_1_US / TICK_US);
	localparam logic [CNT_W-1:0] DLY2P5_TK = CNT_W'(DLY_2P5_US / TICK_US);
	localparam logic [CNT_W-1:0] DLY5_TK = CNT_W'(DLY_5_US / TICK_US);
	localparam logic [CNT_W-1:0] DG1_TK = CNT_W'(DG_1_US / TICK_US);
	localparam logic [CNT_W-1:0] DG5_TK = CNT_W'(DG_5_US / TICK_US);
	localparam logic [CNT_W-1:0] DG10_TK = CNT_W'(DG_10_US / TICK_US);
	localparam logic [CNT_W-1:0] FAULT_TK =
		CNT_W'(FAULT_MS * US_PER_MS / TICK_US);
	localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
	localparam logic [1:0] PRIME_DONE = 2'h3;
	localparam logic [1:0] SEL_0 = 2'h0;
	localparam logic [1:0] SEL_1 = 2'h1;
	localparam logic [1:0] SEL_2 = 2'h2;
	localparam logic [1:0] B2_PRIMARY = 2'h0;
	localparam logic [1:0] B2_SECONDARY = 2'h1;
	localparam logic [1:0] B2_OFF = 2'h2;
	typedef enum logic [2:0] {
		ST_RESET, ST_START, ST_ACTIVE, ST_SLEEP, ST_DEEP_SLEEP_REQUEST_BIT, ST_THERMAL,
		ST_VFAULT
	} lpfsc_state_e;
	typedef struct packed {
		logic sleep_on;
		logic deep_sleep_request_bit_on;
		logic [1:0] on_dly_sel;
		logic [1:0] off_dly_sel;
		logic pin_ctl_en;
		logic [PIN_W-1:0] pin_sel;
	} lpfsc_out_cfg_s;
	typedef struct packed {
		logic uvlo;
		logic vin_ok;
		logic therm;
		logic [NUM_OUT-1:0] ov;
		logic [NUM_OUT-1:0] uv;
		logic [NUM_OUT-1:0] pgood;
		logic [NUM_OUT-1:0] ss_done;
	} lpfsc_ana_s;
	function automatic logic [CNT_W-1:0] lpfsc_dly_ticks(
		input logic [1:0] sel);
		case (sel)
			SEL_0: lpfsc_dly_ticks = DLY0_TK;
			SEL_1: lpfsc_dly_ticks = DLY1_TK;
			SEL_2: lpfsc_dly_ticks = DLY2P5_TK;
			default: lpfsc_dly_ticks = DLY5_TK;
		endcase
	endfunction
	function automatic logic [CNT_W-1:0] lpfsc_dg_ticks(
		input logic [1:0] sel);
		case (sel)
			SEL_0: lpfsc_dg_ticks = DG1_TK;
			SEL_1: lpfsc_dg_ticks = DG5_TK;
			default: lpfsc_dg_ticks = DG10_TK;
		endcase
	endfunction
endpackage
`default_nettype wire

// ---- lpfsc_top.sv ----
// Contract
// R1: each output may be set on or off for light-sleep.
// R2: buck2 in light-sleep: primary, secondary or off; others never swap.
// R3: outputs switch entering/leaving light-sleep only after their delay.
// R4: combine 0: light-sleep needs host bit and all configured sleep pins.
// R5: combine 0: leave light-sleep at once when bit or any pin drops.
// R6: combine 1: enter on bit or any pin; leave when all drop.
// R7: separate deep-sleep on/off per output; second buck three-way.
// R8: outputs switch entering/leaving deep-sleep only after their delay.
// R9: enabled deep-sleep entered on enable pin fall, left on rise.
// R10: level mode: enable pin low at start-up goes straight to deep-sleep.
// R11: edge mode: low at start ignored; needs high then low.
// R12: combine 0: deep-sleep needs host bit and all configured pins.
// R13: combine 0: leave deep-sleep at once when bit or any pin drops.
// R14: combine 1: enter on bit or any pin; leave when all drop.
// R15: pins may switch outputs with 0/1/2.5/5 ms edge delays.
// R16: per-pin polarity and 1/5/10 ms deglitch.
// R17: over-temperature: thermal state, all outputs off, reset asserted.
// R18: thermal mask blocks thermal state; warning status still reports.
// R19: post soft-start over/under-voltage: fault state, outputs off, reset.
// R20: fault state lasts 100 ms then active, repeating while fault stays.
// R21: fault state only with output mask clear and shutdown-disable 0.
// R22: serial-bus reset pulse entering reset, thermal or fault states.
// R23: fault masks are 1 during start-up, cleared after power-up; only ST_START or a mask write clears them, so reset to deep-sleep leaves them at 1.
// R24: undervoltage lockout from any state returns to reset with defaults.
// R25: pins pass two flip-flops before filtering and edge use.
`default_nettype none
module lpfsc_top import lpfsc_pkg::*; #(
	parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire lpfsc_ana_s ana_in,
	input wire logic [NUM_PIN-1:0] gpio_in,
	input wire logic [NUM_PIN-1:0] gpio_polarity_in,
	input wire logic [1:0] deglitch_sel_in,
	input wire logic sleep_request_bit_in,
	input wire logic sleep_combine_sel_in,
	input wire logic deep_sleep_request_bit_in,
	input wire logic deep_sleep_combine_sel_in,
	input wire logic [NUM_PIN-1:0] sleep_pin_sel_in,
	input wire logic [NUM_PIN-1:0] deep_sleep_pin_sel_in,
	input wire logic [NUM_PIN-1:0] power_enable_pin_sel_in,
	input wire logic power_enable_edge_mode_in,
	input wire lpfsc_out_cfg_s [NUM_OUT-1:0] out_cfg_in,
	input wire logic [1:0] buck2_sleep_mode_in,
	input wire logic [1:0] buck2_deep_mode_in,
	input wire logic [1:0] pin_rise_dly_sel_in,
	input wire logic [1:0] pin_fall_dly_sel_in,
	input wire logic thermal_state_mask_in,
	input wire logic voltage_fault_shutdown_disable_in,
	input wire logic mask_wr_in,
	input wire logic [NUM_OUT-1:0] overvoltage_mask_wdata_in,
	input wire logic [NUM_OUT-1:0] undervoltage_mask_wdata_in,
	output lpfsc_state_e state_out,
	output logic [NUM_OUT-1:0] out_en_out,
	output logic buck2_secondary_out,
	output logic reset_n_out,
	output logic thermal_warning_status_out,
	output logic [NUM_OUT-1:0] overvoltage_mask_out,
	output logic [NUM_OUT-1:0] undervoltage_mask_out,
	output logic serial_bus_reset_out
);
	// ************************************************
	// state
	// ************************************************
	typedef struct packed {
		lpfsc_state_e st;
		lpfsc_ana_s s1;
		lpfsc_ana_s s2;
		logic [15:0] pre;
		logic [CNT_W-1:0] flt_cnt;
		logic [NUM_OUT-1:0] ov_mask;
		logic [NUM_OUT-1:0] uv_mask;
		logic armed;
		logic bus_rst;
		logic b2_sec;
		logic therm_warn;
	} lpfsc_top_s;
	lpfsc_top_s q, d;
	lpfsc_ana_s a;
	logic tick;
	logic pins_ready;
	logic [NUM_PIN-1:0] pin_lvl;
	logic sleep_req, dp_req;
	logic pw_cfg, pw_lvl, pw_asrt;
	logic dp_and, dp_or;
	logic therm_ev, vfault_ev, ok;
	logic force_off;
	logic [NUM_OUT-1:0] tgt;
	logic [NUM_OUT-1:0][1:0] on_sel, off_sel;
	assign a = q.s2;
	// ************************************************
	// half millisecond enable
	// ************************************************
	assign tick = q.pre == 16'(TICK_CYCLES - 1);
	// ************************************************
	// pin conditioning
	// ************************************************
	lpfsc_pin_cond u_pins (
		.ref_clk_in(ref_clk_in),
		.rst_in(rst_in),
		.tick_in(tick),
		.pin_in(gpio_in),
		.polarity_in(gpio_polarity_in),
		.deglitch_sel_in(deglitch_sel_in),
		.level_out(pin_lvl),
		.ready_out(pins_ready)
	);
	// ************************************************
	// sleep and deep-sleep requests
	// ************************************************
	always_comb begin
		// R4: and of bit with pins
		// R6: or of bit with pins
		if (sleep_combine_sel_in) begin
			sleep_req = sleep_request_bit_in ||
				(|(pin_lvl & sleep_pin_sel_in));
		end else begin
			sleep_req = sleep_request_bit_in &&
				(&(pin_lvl | ~sleep_pin_sel_in));
		end
	end
	assign pw_cfg = |power_enable_pin_sel_in;
	assign pw_lvl = |(pin_lvl & power_enable_pin_sel_in);
	// R10: level mode always armed
	// R11: edge mode needs high first
	assign pw_asrt = pw_cfg && !pw_lvl &&
		(q.armed || !power_enable_edge_mode_in);
	// R9: enable pin low requests
	assign dp_and = (&(pin_lvl | ~deep_sleep_pin_sel_in)) &&
		(!pw_cfg || pw_asrt);
	assign dp_or = (|(pin_lvl & deep_sleep_pin_sel_in)) || pw_asrt;
	// R12: and combine
	// R14: or combine
	assign dp_req = deep_sleep_combine_sel_in ?
		(deep_sleep_request_bit_in || dp_or) :
		(deep_sleep_request_bit_in && dp_and);
	// ************************************************
	// fault qualification
	// ************************************************
	// R18: mask blocks entry only
	assign therm_ev = a.therm && !thermal_state_mask_in;
	// R21: masks and disable gate
	assign vfault_ev = !voltage_fault_shutdown_disable_in &&
		(|(((a.ov & ~q.ov_mask) | (a.uv & ~q.uv_mask)) & a.ss_done));
	assign ok = !a.uvlo && !therm_ev && !vfault_ev;
	// ************************************************
	// state machine
	// ************************************************
	always_comb begin
		d = q;
		d.s1 = ana_in;
		d.s2 = q.s1;
		d.pre = tick ? '0 : q.pre + 16'h0001;
		d.bus_rst = 1'b0;
		d.therm_warn = a.therm;
		// R11: remember a high level
		if (pw_lvl && pins_ready) begin
			d.armed = 1'b1;
		end
		if (mask_wr_in) begin
			d.ov_mask = overvoltage_mask_wdata_in;
			d.uv_mask = undervoltage_mask_wdata_in;
		end
		case (q.st)
			ST_RESET: begin
				// R10: deep-sleep straight from reset
				if (a.vin_ok && pins_ready) begin
					d.st = dp_req ? ST_DEEP_SLEEP_REQUEST_BIT : ST_START;
				end
			end
			ST_START: begin
				// R23: clear masks once powered
				if (&a.pgood) begin
					d.ov_mask = '0;
					d.uv_mask = '0;
					if (dp_req) begin
						d.st = ST_DEEP_SLEEP_REQUEST_BIT;
					end else if (sleep_req) begin
						d.st = ST_SLEEP;
					end else begin
						d.st = ST_ACTIVE;
					end
				end
			end
			ST_ACTIVE: begin
				if (dp_req) begin
					d.st = ST_DEEP_SLEEP_REQUEST_BIT;
				end else if (sleep_req) begin
					d.st = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				// R5: leave at once
				if (dp_req) begin
					d.st = ST_DEEP_SLEEP_REQUEST_BIT;
				end else if (!sleep_req) begin
					d.st = ST_ACTIVE;
				end
			end
			ST_DEEP_SLEEP_REQUEST_BIT: begin
				// R13: leave at once
				if (!dp_req) begin
					d.st = sleep_req ? ST_SLEEP : ST_ACTIVE;
				end
			end
			ST_THERMAL: begin
				if (!a.therm) begin
					d.st = ST_START;
				end
			end
			ST_VFAULT: begin
				// R20: hold then retry
				if (tick) begin
					d.flt_cnt = q.flt_cnt + CNT_ONE;
					if (q.flt_cnt == FAULT_TK - CNT_ONE) begin
						d.st = ST_ACTIVE;
					end
				end
			end
			default: begin
				d.st = ST_RESET;
			end
		endcase
		// R17: thermal wins over faults
		if (therm_ev && q.st != ST_RESET && q.st != ST_THERMAL) begin
			d.st = ST_THERMAL;
		end else if (vfault_ev && (q.st == ST_ACTIVE ||
			q.st == ST_SLEEP || q.st == ST_DEEP_SLEEP_REQUEST_BIT)) begin
			// R19: regulation loss shuts down
			d.st = ST_VFAULT;
		end
		// R24: lockout overrides all
		if (a.uvlo) begin
			d.st = ST_RESET;
			d.ov_mask = '1;
			d.uv_mask = '1;
			d.armed = 1'b0;
		end
		if (d.st != q.st) begin
			d.flt_cnt = '0;
		end
		// R22: bus reset on entry
		if (d.st != q.st && (d.st == ST_RESET ||
			d.st == ST_THERMAL || d.st == ST_VFAULT)) begin
			d.bus_rst = 1'b1;
		end
		// R2: only buck2 swaps setting
		d.b2_sec = (d.st == ST_SLEEP &&
			buck2_sleep_mode_in == B2_SECONDARY) ||
			(d.st == ST_DEEP_SLEEP_REQUEST_BIT && buck2_deep_mode_in == B2_SECONDARY);
	end
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			q <= '0;
			q.st <= ST_RESET;
			q.ov_mask <= '1;
			q.uv_mask <= '1;
		end else begin
			q <= d;
		end
	end
	// ************************************************
	// output targets
	// ************************************************
	assign force_off = q.st == ST_RESET || q.st == ST_THERMAL ||
		q.st == ST_VFAULT;
	genvar g;
	for (g = 0; g < NUM_OUT; g++) begin : g_tgt
		logic base, pin_on;
		always_comb begin
			case (q.st)
				// R1: sleep on/off per output
				ST_SLEEP: base = (g == BUCK2_IDX) ?
					buck2_sleep_mode_in != B2_OFF : out_cfg_in[g].sleep_on;
				// R7: deep-sleep set apart
				ST_DEEP_SLEEP_REQUEST_BIT: base = (g == BUCK2_IDX) ?
					buck2_deep_mode_in != B2_OFF : out_cfg_in[g].deep_sleep_request_bit_on;
				ST_START, ST_ACTIVE: base = 1'b1;
				default: base = 1'b0;
			endcase
		end
		// R15: pin gating with edge delays
		assign pin_on = !out_cfg_in[g].pin_ctl_en ||
			pin_lvl[out_cfg_in[g].pin_sel];
		assign tgt[g] = base && pin_on;
		// R8: delays on every transition except forced shutdown, which drops outputs at once
		assign on_sel[g] = out_cfg_in[g].pin_ctl_en ?
			pin_rise_dly_sel_in : out_cfg_in[g].on_dly_sel;
		assign off_sel[g] = out_cfg_in[g].pin_ctl_en ?
			pin_fall_dly_sel_in : out_cfg_in[g].off_dly_sel;
	end
	lpfsc_out_seq u_seq (
		.ref_clk_in(ref_clk_in),
		.rst_in(rst_in),
		.tick_in(tick),
		.force_off_in(force_off),
		.target_in(tgt),
		.on_sel_in(on_sel),
		.off_sel_in(off_sel),
		.en_out(out_en_out)
	);
	// ************************************************
	// outputs
	// ************************************************
	assign state_out = q.st;
	// R17: reset low while shut down
	assign reset_n_out = !force_off;
	assign buck2_secondary_out = q.b2_sec;
	assign thermal_warning_status_out = q.therm_warn;
	assign overvoltage_mask_out = q.ov_mask;
	assign undervoltage_mask_out = q.uv_mask;
	assign serial_bus_reset_out = q.bus_rst;
	// ************************************************
	// checks
	// ************************************************
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);
	sequence s_fault_hold;
		q.st == ST_VFAULT ##1 q.st == ST_ACTIVE;
	endsequence
	sequence s_powered;
		q.st == ST_START ##1 q.st inside {ST_ACTIVE, ST_SLEEP, ST_DEEP_SLEEP_REQUEST_BIT};
	endsequence
	AST_UVLO_RESET: assert property ( // R24
		a.uvlo |=> q.st == ST_RESET && q.ov_mask == '1 && !q.armed)
		else $error("lockout did not restore defaults");
	AST_THERM_ENTRY: assert property ( // R17
		(q.st == ST_ACTIVE && therm_ev && !a.uvlo) |=>
		q.st == ST_THERMAL ##0 !reset_n_out ##1 out_en_out == '0)
		else $error("thermal shutdown incomplete");
	AST_THERM_MASK: assert property ( // R18
		(thermal_state_mask_in && q.st != ST_THERMAL) |=>
		q.st != ST_THERMAL)
		else $error("masked thermal state entered");
	AST_FAULT_TIME: assert property ( // R20
		s_fault_hold |-> $past(q.flt_cnt) == FAULT_TK - CNT_ONE)
		else $error("fault state left early");
	AST_FAULT_GATE: assert property ( // R21
		$rose(q.st == ST_VFAULT) |-> !$past(voltage_fault_shutdown_disable_in))
		else $error("fault state despite shutdown disable");
	AST_BUS_RST: assert property ( // R22
		($changed(q.st) && q.st inside {ST_RESET, ST_THERMAL, ST_VFAULT})
		|-> serial_bus_reset_out)
		else $error("serial bus not reset on entry");
	AST_MASK_CLR: assert property ( // R23
		s_powered |-> q.ov_mask == '0 && q.uv_mask == '0)
		else $error("fault masks not cleared after power-up");
	AST_SLEEP_ENTER: assert property ( // R4
		(q.st == ST_ACTIVE && sleep_req && !dp_req && ok) |=>
		q.st == ST_SLEEP)
		else $error("light-sleep not entered");
	AST_SLEEP_EXIT: assert property ( // R5
		(q.st == ST_SLEEP && !sleep_req && !dp_req && ok) |=>
		q.st == ST_ACTIVE)
		else $error("light-sleep not left");
	AST_DEEP_EXIT: assert property ( // R13
		(q.st == ST_DEEP_SLEEP_REQUEST_BIT && !dp_req && !sleep_req && ok) |=>
		q.st == ST_ACTIVE)
		else $error("deep-sleep not left");
endmodule // lpfsc_top
`default_nettype wire
